/* File: rtl/dcr_device_control.v */
`include "dcr_map.vh"
// Function
// R1 - bit 0 selects forced duplex, 1 full
// R2 - bit 2 blocks new bus requests, reports idle
// R3 - internal phy link ignored unless bit 6
// R4 - link-up enable resets 0, 1 with wake
// R5 - serial modes: bit 6 forces link up
// R6 - bit 7 inverts signal-detect or link polarity
// R7 - invert bit reset only by power/pcie reset
// R8 - speed field 9:8 resets to 1000
// R9 - speed field ignored under auto speed detect
// R10 - bit 11 forces speed; bypass overrides it
// R11 - duplex sampled at link rise unless forced
// R12 - bits 16/17 enable pin input interrupts
// R13 - bits 18/19 drive pins, read pin level
// R14 - direction bits survive soft and system reset
// R15 - bit 21 puts watchdog on pin 0
// R16 - bit 20 low suppresses cold wake
// R17 - bit 26 self-clearing port reset
// R18 - bit 27 enables pause reception, negotiated
// R19 - bit 28 enables pause transmission, reset 0
// R20 - bit 29 chip reset if permitted, flags
// R21 - bit 30 strips vlan tags
// R22 - bit 31 holds copper phy in reset
// R23 - chip reset seen flag cleared by one
// R24 - phy reset seen flag set, cleared by zero
module dcr_device_control (
    sys_clk,
    rst,
    powerOnRst,
    regAddr,
    regWdata,
    regWr,
    regRd,
    regRdata,
    serialMode,
    energySourceSelect,
    serialSignalDetect,
    phyLink,
    phyDuplexIndication,
    phySpeed,
    autoSpeedDetect,
    autoSpeedValue,
    speedBypass,
    powerMgmtWakeEnable,
    coldWakeDefault,
    chipResetPermit,
    anDone,
    anRxPause,
    anTxPause,
    busPending,
    inD3cold,
    wakeRequest,
    watchdogEvent,
    pin0In,
    pin1In,
    pin0Out,
    pin0Oe,
    pin1Out,
    pin1Oe,
    busRequestBlock,
    linkUp,
    macFullDuplex,
    macSpeed,
    rxPauseEnable,
    txPauseEnable,
    vlanStripEnable,
    copperPhyReset,
    portReset,
    wholeChipReset,
    chipResetInterrupt,
    pinIntr,
    wakeOut
);
    input  wire                   sys_clk;
    input  wire                   rst;
    input  wire                   powerOnRst;
    input  wire [`DCR_ADDR_W-1:0] regAddr;
    input  wire [31:0]            regWdata;
    input  wire                   regWr;
    input  wire                   regRd;
    output reg  [31:0]            regRdata;
    input  wire                   serialMode;
    input  wire                   energySourceSelect;
    input  wire                   serialSignalDetect;
    input  wire                   phyLink;
    input  wire                   phyDuplexIndication;
    input  wire [1:0]             phySpeed;
    input  wire                   autoSpeedDetect;
    input  wire [1:0]             autoSpeedValue;
    input  wire                   speedBypass;
    input  wire                   powerMgmtWakeEnable;
    input  wire                   coldWakeDefault;
    input  wire                   chipResetPermit;
    input  wire                   anDone;
    input  wire                   anRxPause;
    input  wire                   anTxPause;
    input  wire                   busPending;
    input  wire                   inD3cold;
    input  wire                   wakeRequest;
    input  wire                   watchdogEvent;
    input  wire                   pin0In;
    input  wire                   pin1In;
    output reg                    pin0Out;
    output reg                    pin0Oe;
    output reg                    pin1Out;
    output reg                    pin1Oe;
    output reg                    busRequestBlock;
    output reg                    linkUp;
    output reg                    macFullDuplex;
    output reg  [1:0]             macSpeed;
    output reg                    rxPauseEnable;
    output reg                    txPauseEnable;
    output reg                    vlanStripEnable;
    output reg                    copperPhyReset;
    output wire                   portReset;
    output wire                   wholeChipReset;
    output reg                    chipResetInterrupt;
    output reg                    pinIntr;
    output reg                    wakeOut;

    // control bits and status flags
    reg        fullDuplexSelect_q;
    reg        linkUpEnable_q;
    reg        signalDetectInvert_q;
    reg [1:0]  speedSel_q;
    reg        forceSpeed_q;
    reg        forceDuplex_q;
    reg        pin0IntrEnable_q;
    reg        pin1IntrEnable_q;
    reg        pin0Value_q;
    reg        pin1Value_q;
    reg        coldWakeEnable_q;
    reg        pin0WatchdogMode_q;
    reg        pin0Direction_q;
    reg        pin1Direction_q;
    reg        rxPauseEn_q;
    reg        txPauseEn_q;
    reg        vlanStrip_q;
    reg        phyRst_q;
    reg        chipResetSeenFlag_q;
    reg        phyResetSeenFlag_q;
    reg        sampledDuplex_q;
    reg        linkPrev_q;
    reg        pin0Prev_q;
    reg        pin1Prev_q;

    wire [`DCR_SYNC_W-1:0] syncVec;
    wire       sSigDet;
    wire       sLink;
    wire       sDuplex;
    wire       sPending;
    wire       sWatchdog;
    wire       sPin0;
    wire       sPin1;

    // soft reset covers system reset and both self-clearing resets
    wire       softRst;
    wire       ctrlHit;
    wire       ctrlWr;
    wire       statWr;
    wire       linkRaw;
    wire       linkSense;
    wire       linkRise;
    wire [31:0] ctrlWord;
    wire [31:0] statWord;
    wire [1:0] speedNext;
    wire       duplexNext;
    wire       idleNext;
    wire       pin0Dir;

    function inbit;
        input [31:0] w;
        input integer pos;
        begin
            inbit = w[pos];
        end
    endfunction

    // signal detect, link, duplex, pending, watchdog and pin levels pass two flops
    dcr_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn ({serialSignalDetect, phyLink, phyDuplexIndication, busPending,
                   watchdogEvent, pin0In, pin1In}),
        .syncOut (syncVec)
    );
    assign {sSigDet, sLink, sDuplex, sPending, sWatchdog, sPin0, sPin1} = syncVec;

    // address decode: the control word answers at its alias too
    assign ctrlHit = (regAddr == `DCR_CTRL_ADDR) | (regAddr == `DCR_CTRL_ALIAS);
    assign ctrlWr  = regWr & ctrlHit;
    assign statWr  = regWr & (regAddr == `DCR_STATUS_ADDR);

    // self-clearing resets: pulse one cycle, never stored
    dcr_self_clear u_port_rst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .fire    (ctrlWr & inbit(regWdata, `DCR_PRST_BIT)), // [R17]
        .permit  (1'b1),
        .pulse_q (portReset)
    );
    dcr_self_clear u_chip_rst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .fire    (ctrlWr & inbit(regWdata, `DCR_DRST_BIT)),
        .permit  (chipResetPermit), // [R20]
        .pulse_q (wholeChipReset)
    );
    assign softRst = rst | portReset | wholeChipReset; // [R17]

    // link source polarity: invert applies to signal detect or phy link
    assign linkRaw   = (serialMode | energySourceSelect) ? sSigDet : sLink;
    assign linkSense = linkRaw ^ signalDetectInvert_q; // [R6]
    assign linkRise  = sLink & ~linkPrev_q;

    // ordinary control bits, loaded with their reset defaults by any soft reset
    always @(posedge sys_clk) begin
        if (softRst) begin
            fullDuplexSelect_q <= 1'b1;
            linkUpEnable_q     <= powerMgmtWakeEnable; // [R4]
            speedSel_q         <= `DCR_SPD_RST; // [R8]
            forceSpeed_q       <= 1'b0;
            forceDuplex_q      <= 1'b0;
            pin0IntrEnable_q   <= 1'b0;
            pin1IntrEnable_q   <= 1'b0;
            pin0Value_q        <= 1'b0;
            pin1Value_q        <= 1'b0;
            coldWakeEnable_q   <= coldWakeDefault; // [R16]
            pin0WatchdogMode_q <= 1'b0;
            rxPauseEn_q        <= 1'b1; // [R18]
            txPauseEn_q        <= 1'b0; // [R19]
            vlanStrip_q        <= 1'b0;
            phyRst_q           <= 1'b0;
            busRequestBlock    <= 1'b0;
        end else if (ctrlWr) begin
            fullDuplexSelect_q <= inbit(regWdata, `DCR_DUP_BIT);
            busRequestBlock    <= inbit(regWdata, `DCR_BLOCK_BIT); // [R2]
            linkUpEnable_q     <= inbit(regWdata, `DCR_LUE_BIT);
            speedSel_q         <= regWdata[`DCR_SPD_HI:`DCR_SPD_LO];
            forceSpeed_q       <= inbit(regWdata, `DCR_FSPD_BIT);
            forceDuplex_q      <= inbit(regWdata, `DCR_FDUP_BIT);
            pin0IntrEnable_q   <= inbit(regWdata, `DCR_GPIEN0_BIT);
            pin1IntrEnable_q   <= inbit(regWdata, `DCR_GPIEN1_BIT);
            pin0Value_q        <= inbit(regWdata, `DCR_DATA0_BIT);
            pin1Value_q        <= inbit(regWdata, `DCR_DATA1_BIT);
            coldWakeEnable_q   <= inbit(regWdata, `DCR_WAKE_BIT);
            pin0WatchdogMode_q <= inbit(regWdata, `DCR_WDE_BIT);
            rxPauseEn_q        <= inbit(regWdata, `DCR_RXP_BIT);
            txPauseEn_q        <= inbit(regWdata, `DCR_TXP_BIT);
            vlanStrip_q        <= inbit(regWdata, `DCR_VLAN_BIT);
            phyRst_q           <= inbit(regWdata, `DCR_PHYRST_BIT);
        end else if (anDone) begin
            rxPauseEn_q        <= anRxPause; // [R18]
            txPauseEn_q        <= anTxPause;
        end
    end

    // power-on domain: invert and directions ignore soft resets
    always @(posedge sys_clk) begin
        if (powerOnRst) begin
            signalDetectInvert_q <= 1'b0; // [R7]
            pin0Direction_q      <= 1'b0; // [R14]
            pin1Direction_q      <= 1'b0;
        end else if (ctrlWr) begin
            signalDetectInvert_q <= inbit(regWdata, `DCR_INV_BIT);
            pin0Direction_q      <= inbit(regWdata, `DCR_DIR0_BIT); // [R14]
            pin1Direction_q      <= inbit(regWdata, `DCR_DIR1_BIT);
        end
    end

    // speed: bypass or force picks the field, else auto detect beats the phy speed
    assign speedNext = speedBypass ? speedSel_q :              // [R10]
                       forceSpeed_q ? speedSel_q :             // [R10]
                       autoSpeedDetect ? autoSpeedValue :      // [R9]
                       phySpeed;
    assign duplexNext = forceDuplex_q ? fullDuplexSelect_q : sampledDuplex_q; // [R11]
    assign idleNext   = ~(busRequestBlock & sPending);

    // mac state derived from the control bits
    always @(posedge sys_clk) begin
        if (softRst) begin
            sampledDuplex_q <= 1'b1;
            linkPrev_q      <= 1'b0;
            linkUp          <= 1'b0;
            macSpeed        <= `DCR_SPD_1000;
            macFullDuplex   <= 1'b1;
        end else begin
            linkPrev_q <= sLink;
            if (linkRise) begin
                sampledDuplex_q <= sDuplex; // [R11]
            end
            if (serialMode) begin
                linkUp <= linkUpEnable_q | linkSense; // [R5]
            end else begin
                linkUp <= linkUpEnable_q & linkSense; // [R3]
            end
            macSpeed      <= speedNext;
            macFullDuplex <= duplexNext; // [R1]
        end
    end

    // status flags: hardware set wins over software clear
    always @(posedge sys_clk) begin
        if (powerOnRst) begin
            chipResetSeenFlag_q <= 1'b0;
            phyResetSeenFlag_q  <= 1'b1;
        end else begin
            if (wholeChipReset) begin
                chipResetSeenFlag_q <= 1'b1; // [R20]
            end else if (statWr & inbit(regWdata, `DCR_ST_DRSTS_BIT)) begin
                chipResetSeenFlag_q <= 1'b0; // [R23]
            end
            if (phyRst_q) begin
                phyResetSeenFlag_q <= 1'b1; // [R24]
            end else if (statWr & ~inbit(regWdata, `DCR_ST_PRS_BIT)) begin
                phyResetSeenFlag_q <= 1'b0; // [R24]
            end
        end
    end

    // pins, interrupts, wake and datapath enables
    assign pin0Dir = pin0Direction_q | pin0WatchdogMode_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            pin0Out            <= 1'b0;
            pin0Oe             <= 1'b0;
            pin1Out            <= 1'b0;
            pin1Oe             <= 1'b0;
            pin0Prev_q         <= 1'b0;
            pin1Prev_q         <= 1'b0;
            pinIntr            <= 1'b0;
            wakeOut            <= 1'b0;
            chipResetInterrupt <= 1'b0;
            rxPauseEnable      <= 1'b0;
            txPauseEnable      <= 1'b0;
            vlanStripEnable    <= 1'b0;
            copperPhyReset     <= 1'b0;
            regRdata           <= `DCR_ZERO32;
        end else begin
            // watchdog mode: pin 0 shows the event at the data polarity
            pin0Out <= pin0WatchdogMode_q ? (sWatchdog ~^ pin0Value_q) // [R15]
                                          : pin0Value_q;               // [R13]
            pin0Oe  <= pin0Dir; // [R15]
            pin1Out <= pin1Value_q; // [R13]
            pin1Oe  <= pin1Direction_q;
            pin0Prev_q <= sPin0;
            pin1Prev_q <= sPin1;
            // rising pin edge while input and enabled
            pinIntr <= (pin0IntrEnable_q & ~pin0Dir & sPin0 & ~pin0Prev_q) |
                       (pin1IntrEnable_q & ~pin1Direction_q & sPin1 & ~pin1Prev_q); // [R12]
            wakeOut <= wakeRequest & (coldWakeEnable_q | ~inD3cold); // [R16]
            chipResetInterrupt <= wholeChipReset; // [R20]
            rxPauseEnable   <= rxPauseEn_q; // [R18]
            txPauseEnable   <= txPauseEn_q; // [R19]
            vlanStripEnable <= vlanStrip_q; // [R21]
            copperPhyReset  <= phyRst_q; // [R22]
            // read data stand one cycle after the strobe only
            if (regRd & ctrlHit) begin
                regRdata <= ctrlWord;
            end else if (regRd & (regAddr == `DCR_STATUS_ADDR)) begin
                regRdata <= statWord;
            end else begin
                regRdata <= `DCR_ZERO32;
            end
        end
    end

    // read images; input pins read their live level
    assign ctrlWord = {phyRst_q, vlanStrip_q, 1'b0, txPauseEn_q, rxPauseEn_q, 3'h0,
                       pin1Direction_q, pin0Direction_q, pin0WatchdogMode_q,
                       coldWakeEnable_q,
                       (pin1Direction_q ? pin1Value_q : sPin1), // [R13]
                       (pin0Dir ? pin0Value_q : sPin0),         // [R13]
                       pin1IntrEnable_q, pin0IntrEnable_q, 3'h0,
                       forceDuplex_q, forceSpeed_q, 1'b0, speedSel_q,
                       signalDetectInvert_q, linkUpEnable_q, 3'h0,
                       busRequestBlock, 1'b0, fullDuplexSelect_q} & `DCR_CTRL_WMASK;
    assign statWord = {11'h000, chipResetSeenFlag_q, idleNext, 8'h00, // [R2]
                       phyResetSeenFlag_q, 2'h0, macSpeed, 4'h0, linkUp,
                       macFullDuplex};
endmodule // dcr_device_control

/* File: rtl/dcr_map.vh */
`ifndef DCR_MAP_VH
`define DCR_MAP_VH
// register byte addresses
`define DCR_ADDR_W          16
`define DCR_CTRL_ADDR       16'h0000
`define DCR_CTRL_ALIAS      16'h0004
`define DCR_STATUS_ADDR     16'h0008
// control field positions
`define DCR_DUP_BIT         0
`define DCR_BLOCK_BIT       2
`define DCR_LUE_BIT         6
`define DCR_INV_BIT         7
`define DCR_SPD_LO          8
`define DCR_SPD_HI          9
`define DCR_FSPD_BIT        11
`define DCR_FDUP_BIT        12
`define DCR_GPIEN0_BIT      16
`define DCR_GPIEN1_BIT      17
`define DCR_DATA0_BIT       18
`define DCR_DATA1_BIT       19
`define DCR_WAKE_BIT        20
`define DCR_WDE_BIT         21
`define DCR_DIR0_BIT        22
`define DCR_DIR1_BIT        23
`define DCR_PRST_BIT        26
`define DCR_RXP_BIT         27
`define DCR_TXP_BIT         28
`define DCR_DRST_BIT        29
`define DCR_VLAN_BIT        30
`define DCR_PHYRST_BIT      31
// writable control bits; reserved bits read zero
`define DCR_CTRL_WMASK      32'hFCFF1BC5
// status field positions
`define DCR_ST_DUP_BIT      0
`define DCR_ST_LU_BIT       1
`define DCR_ST_SPD_LO       6
`define DCR_ST_SPD_HI       7
`define DCR_ST_PRS_BIT      10
`define DCR_ST_IDLE_BIT     19
`define DCR_ST_DRSTS_BIT    20
// reset values
`define DCR_SPD_RST         2'h2
`define DCR_SPD_1000        2'h2
`define DCR_ZERO32          32'h00000000
`define DCR_SYNC_W          7
`endif

/* File: rtl/dcr_sync.v */
`include "dcr_map.vh"
// two-flop synchroniser for pin-side levels; stage one feeds only stage two
module dcr_sync (
    sys_clk,
    rst,
    asyncIn,
    syncOut
);
    input  wire                   sys_clk;
    input  wire                   rst;
    input  wire [`DCR_SYNC_W-1:0] asyncIn;
    output reg  [`DCR_SYNC_W-1:0] syncOut;

    reg [`DCR_SYNC_W-1:0] meta_q;

    // both stages clear on reset so consumers see a known level
    always @(posedge sys_clk) begin
        if (rst) begin
            meta_q  <= {`DCR_SYNC_W{1'b0}};
            syncOut <= {`DCR_SYNC_W{1'b0}};
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // dcr_sync

/* File: rtl/dcr_self_clear.v */
`include "dcr_map.vh"
// one-cycle pulse from a written one; the stored bit never reads back set
module dcr_self_clear (
    sys_clk,
    rst,
    fire,
    permit,
    pulse_q
);
    input  wire sys_clk;
    input  wire rst;
    input  wire fire;
    input  wire permit;
    output reg  pulse_q;

    // a refused write leaves nothing behind, so no stale request survives
    always @(posedge sys_clk) begin
        if (rst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= fire & permit;
        end
    end
endmodule // dcr_self_clear

/* File: test/dcr_device_control_sva.sv */
`include "dcr_map.vh"
// watches the control word's write side and the reset pulses it launches
module dcr_device_control_sva (
    input logic        sys_clk,
    input logic        rst,
    input logic        powerOnRst,
    input logic [15:0] regAddr,
    input logic [31:0] regWdata,
    input logic        regWr,
    input logic        chipResetPermit,
    input logic        portReset,
    input logic        wholeChipReset,
    input logic        chipResetInterrupt,
    input logic        vlanStripEnable,
    input logic        txPauseEnable,
    input logic        copperPhyReset,
    input logic        busRequestBlock,
    input logic        pin1Oe,
    input logic        pinIntr,
    input logic        anDone
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || powerOnRst);
    // a reset pulse in flight would swallow the write, so such writes are left out
    wire ctrlWr  = regWr && (regAddr == 16'h0000 || regAddr == 16'h0004)
                   && !portReset && !wholeChipReset;
    wire plainWr = ctrlWr && !regWdata[26] && !regWdata[29];

    a_port_pulse: assert property (portReset |=> !portReset)
        else $error("port reset longer than one cycle");
    a_port_cause: assert property (ctrlWr && regWdata[26] |=> portReset)
        else $error("port reset bit did not fire");
    a_chip_refused: assert property (ctrlWr && regWdata[29] && !chipResetPermit
        |=> !wholeChipReset)
        else $error("chip reset fired without permit");
    a_chip_irq: assert property (wholeChipReset |=> chipResetInterrupt)
        else $error("chip reset interrupt missing");
    a_irq_cause: assert property (chipResetInterrupt |-> $past(wholeChipReset))
        else $error("chip reset interrupt without chip reset");
    a_vlan_follow: assert property (plainWr
        |=> ##1 vlanStripEnable == $past(regWdata[30], 2))
        else $error("vlan strip enable not loaded");
    a_phy_follow: assert property (plainWr
        |=> ##1 copperPhyReset == $past(regWdata[31], 2))
        else $error("phy reset not loaded");
    a_block_follow: assert property (plainWr |=> busRequestBlock == $past(regWdata[2]))
        else $error("bus request block not loaded");
    a_tx_pause: assert property (plainWr && !anDone
        |=> ##1 txPauseEnable == $past(regWdata[28], 2))
        else $error("tx pause enable not loaded");
    a_pin_dir: assert property (plainWr |=> ##1 pin1Oe == $past(regWdata[23], 2))
        else $error("pin one direction not loaded");

    c_plain_write: cover property (plainWr);
    c_chip_reset: cover property (wholeChipReset);
    c_pin_intr: cover property (pinIntr);
endmodule // dcr_device_control_sva

bind dcr_device_control dcr_device_control_sva i_sva (.*);

/* File: test/dcr_device_control_test.sv */
`include "dcr_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module dcr_device_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CA = `DCR_CTRL_ADDR;
    localparam logic [15:0] AA = `DCR_CTRL_ALIAS;
    localparam logic [15:0] SA = `DCR_STATUS_ADDR;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    // full duplex, speed 10b, cold wake, rx pause; link-up enable follows wake-enable tie (0)
    localparam logic [31:0] RSTW = 32'h08100201;
    logic        sys_clk, rst, powerOnRst, regWr, regRd, serialMode, energySourceSelect;
    logic        serialSignalDetect, phyLink, phyDuplexIndication, autoSpeedDetect;
    logic        speedBypass, powerMgmtWakeEnable, coldWakeDefault, chipResetPermit;
    logic        anDone, anRxPause, anTxPause, busPending, inD3cold, wakeRequest;
    logic        watchdogEvent, ext0, ext1, rdSeen;
    logic [1:0]  phySpeed, autoSpeedValue;
    logic [15:0] regAddr;
    logic [31:0] regWdata, r, w, e, qe, qm;
    logic [31:0] expQ[$], mskQ[$];
    wire  [31:0] regRdata;
    wire         pin0Out, pin0Oe, pin1Out, pin1Oe, busRequestBlock, linkUp, macFullDuplex;
    wire  [1:0]  macSpeed;
    wire         rxPauseEnable, txPauseEnable, vlanStripEnable, copperPhyReset, portReset;
    wire         wholeChipReset, chipResetInterrupt, pinIntr, wakeOut, pin0In, pin1In;
    int          err_count, check_count, cycles, nPort, nChip, nIrq, nIntr;

    // pin level: the block wins while it drives, else the outside world
    assign pin0In = pin0Oe ? pin0Out : ext0;
    assign pin1In = pin1Oe ? pin1Out : ext1;

    dcr_device_control i_dut (.*);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge sys_clk) rdSeen <= regRd;
    always @(negedge sys_clk) begin
        nPort += (portReset === 1'b1);
        nChip += (wholeChipReset === 1'b1);
        nIrq += (chipResetInterrupt === 1'b1);
        nIntr += (pinIntr === 1'b1);
        if (rdSeen === 1'b1) begin
            qe = expQ.pop_front();
            qm = mskQ.pop_front();
            `CHK(regRdata & qm, qe)
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m);
        expQ.push_back(x & m);
        mskQ.push_back(m);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
    endtask

    // status read after synchronisers and derived outputs have settled
    task automatic st(input logic [31:0] x, input logic [31:0] m);
        repeat (4) @(posedge sys_clk);
        rd(SA, x, m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    initial begin
        {regWr, regRd, serialMode, energySourceSelect, serialSignalDetect, phyLink} = '0;
        {phyDuplexIndication, autoSpeedDetect, speedBypass, powerMgmtWakeEnable} = '0;
        {chipResetPermit, anDone, anRxPause, anTxPause, busPending, inD3cold} = '0;
        {wakeRequest, watchdogEvent, ext0, ext1, phySpeed, autoSpeedValue} = '0;
        {regAddr, regWdata, rdSeen} = '0;
        coldWakeDefault = 1'b1;
        rst = 1'b1;
        powerOnRst = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        powerOnRst <= 1'b0;
        rd(CA, RSTW, ALL);
        rd(SA, 32'h00080400, 32'h00180400);
        // random words through both addresses; self-clear and watchdog bits kept out
        r = 32'h000037F3;
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            w = r & `DCR_CTRL_WMASK & 32'hDBDFFFFF;
            e = w;
            e[18] = w[22] & w[18];
            e[19] = w[23] & w[19];
            wr(i[0] ? AA : CA, w);
            cyc(2);
            rd(i[0] ? CA : AA, e, ALL);
        end
        wr(16'h0010, ALL);
        rd(16'h000C, 32'h0, ALL);
        rd(CA, e, ALL);
        // block, tx pause, vlan, phy reset, pin0 driven high, pin1 input with detect
        wr(CA, 32'hD0460004);
        cyc(1);
        `CHK({vlanStripEnable, txPauseEnable, rxPauseEnable, copperPhyReset}, 4'hD)
        `CHK({busRequestBlock, pin0Oe, pin0Out, pin1Oe}, 4'hE)
        @(posedge sys_clk);
        busPending <= 1'b1;
        st(32'h0, 32'h00080000);
        @(posedge sys_clk);
        busPending <= 1'b0;
        st(32'h00080000, 32'h00080000);
        wr(SA, 32'h0);
        rd(SA, 32'h400, 32'h400);
        nIntr = 0;
        @(posedge sys_clk);
        ext1 <= 1'b1;
        cyc(6);
        `CHK(nIntr, 1)
        wr(CA, 32'hD0440004);
        ext1 <= 1'b0;
        cyc(3);
        ext1 <= 1'b1;
        cyc(6);
        `CHK(nIntr, 1)
        wr(CA, 32'h0);
        wr(SA, 32'h0);
        rd(SA, 32'h0, 32'h400);
        // watchdog on pin0, polarity high
        wr(CA, 32'h00240000);
        watchdogEvent <= 1'b1;
        inD3cold <= 1'b1;
        wakeRequest <= 1'b1;
        cyc(4);
        `CHK({pin0Oe, pin0Out, wakeOut}, 3'h6)
        @(posedge sys_clk);
        watchdogEvent <= 1'b0;
        wr(CA, 32'h00100000);
        cyc(4);
        `CHK(wakeOut, 1'b1)
        @(posedge sys_clk);
        watchdogEvent <= 1'b1;
        cyc(4);
        `CHK({pin0Oe, pin0Out}, 2'h0)
        // link: internal phy needs the enable, serial modes force or invert
        @(posedge sys_clk);
        phyLink <= 1'b1;
        wr(CA, 32'h0);
        st(32'h0, 32'h2);
        wr(CA, 32'h40);
        st(32'h2, 32'h2);
        serialMode <= 1'b1;
        energySourceSelect <= 1'b1;
        st(32'h2, 32'h2);
        wr(CA, 32'h80);
        st(32'h2, 32'h2);
        wr(CA, 32'h0);
        st(32'h0, 32'h2);
        serialMode <= 1'b0;
        wr(CA, 32'h0900);
        st(32'h40, 32'hC0);
        speedBypass <= 1'b1;
        wr(CA, 32'h0);
        st(32'h0, 32'hC0);
        speedBypass <= 1'b0;
        autoSpeedDetect <= 1'b1;
        autoSpeedValue <= 2'h1;
        wr(CA, 32'h0300);
        st(32'h40, 32'hC0);
        wr(CA, 32'h1000);
        st(32'h0, 32'h1);
        wr(CA, 32'h1001);
        st(32'h1, 32'h1);
        wr(CA, 32'h1000);
        phyDuplexIndication <= 1'b1;
        phyLink <= 1'b0;
        wr(CA, 32'h40);
        phyLink <= 1'b1;
        st(32'h1, 32'h1);
        phyDuplexIndication <= 1'b0;
        st(32'h1, 32'h1);
        // port reset keeps directions and invert
        nPort = 0;
        wr(CA, 32'h44C00080);
        cyc(3);
        `CHK(nPort, 1)
        rd(CA, RSTW | 32'h00C00080, ALL);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        rd(CA, RSTW | 32'h00C00080, ALL);
        @(posedge sys_clk);
        rst <= 1'b1;
        powerOnRst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        powerOnRst <= 1'b0;
        rd(CA, RSTW, ALL);
        // chip reset refused, then permitted
        nChip = 0;
        nIrq = 0;
        wr(CA, 32'h20000000);
        cyc(3);
        `CHK(nChip, 0)
        chipResetPermit <= 1'b1;
        wr(CA, 32'h20000000);
        cyc(3);
        `CHK(nChip + nIrq, 2)
        rd(SA, 32'h00100000, 32'h00100000);
        wr(SA, 32'h00100000);
        rd(SA, 32'h0, 32'h00100000);
        // negotiated pause values land on completion
        anRxPause <= 1'b1;
        anTxPause <= 1'b1;
        anDone <= 1'b1;
        @(posedge sys_clk);
        anDone <= 1'b0;
        cyc(1);
        `CHK({rxPauseEnable, txPauseEnable}, 2'h3)
        cyc(2);
        finish_test();
    end
endmodule // dcr_device_control_test
